// file: design/sats_regs.vh
`ifndef SATS_REGS_VH
`define SATS_REGS_VH

// special function register addresses
`define SATS_ADDR_CTRL 8'hC8
`define SATS_ADDR_RELOAD_LOW 8'hCA
`define SATS_ADDR_RELOAD_HIGH 8'hCB
`define SATS_ADDR_COUNT_LOW 8'hCC
`define SATS_ADDR_COUNT_HIGH 8'hCD
`define SATS_ADDR_CLOCK_CONTROL 8'h8E

// control register fields
`define SATS_CTRL_HIGH_OVF 7
`define SATS_CTRL_LOW_OVF 6
`define SATS_CTRL_LOW_IRQ_EN 5
`define SATS_CTRL_CAPTURE_EN 4
`define SATS_CTRL_SPLIT 3
`define SATS_CTRL_RUN 2
`define SATS_CTRL_SEL_HI 1
`define SATS_CTRL_SEL_LO 0

// clock control register fields
`define SATS_CKC_HIGH_CHOICE 5
`define SATS_CKC_LOW_CHOICE 4

// external source select codes
`define SATS_SEL_DIV12_A 2'h0
`define SATS_SEL_COMPARATOR 2'h1
`define SATS_SEL_DIV12_B 2'h2
`define SATS_SEL_RTC_DIV8 2'h3

// reset values
`define SATS_RESET_BYTE 8'h00
`define SATS_RESET_CKC 8'h00

// divider counts
`define SATS_SYSTEM_CLOCK_DIV 4'hC
`define SATS_RTC_DIV 3'h7

`endif

// file: design/sats_timer.v
`include "sats_regs.vh"
`default_nettype none

module sats_timer (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // asynchronous sources
  input wire comparator_out,
  input wire rtc_osc,
  // interrupt
  input wire timer_irq_enable,
  output reg timer_irq,
  // capture trigger
  output reg capture_trigger
);

  // byte reaches its top value and wraps on the next increment
  function byte_top;
    input [7:0] value;
    begin
      byte_top = (value == 8'hFF);
    end
  endfunction

  reg [7:0] reload_low_byte_reg;
  reg [7:0] reload_high_byte_reg;
  reg [7:0] count_low_byte_reg;
  reg [7:0] count_high_byte_reg;
  reg [7:0] clock_control_reg;
  reg high_overflow_flag_reg;
  reg low_overflow_flag_reg;
  reg low_overflow_irq_enable_reg;
  reg capture_enable_reg;
  reg split_mode_enable_reg;
  reg run_control_reg;
  reg [1:0] external_source_select_reg;

  ////////////////////////////////////////////////////////////////////////////
  // synchronizers and dividers

  reg [2:0] cmp_sync_reg;
  reg [2:0] rtc_sync_reg;
  reg cmp_level_reg;
  reg rtc_level_reg;
  reg [3:0] div12_reg;
  reg [2:0] rtc_div_reg;
  wire cmp_rise;
  wire rtc_rise;
  wire div12_tick;
  wire rtc8_tick;

  // three stage capture, level accepted once stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      cmp_sync_reg <= 3'h0;
      rtc_sync_reg <= 3'h0;
      cmp_level_reg <= 1'b0;
      rtc_level_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_out};
      rtc_sync_reg <= {rtc_sync_reg[1:0], rtc_osc};
      if (cmp_sync_reg[1] == cmp_sync_reg[2])
        cmp_level_reg <= cmp_sync_reg[2];
      if (rtc_sync_reg[1] == rtc_sync_reg[2])
        rtc_level_reg <= rtc_sync_reg[2];
    end
  end

  // rising edges of the accepted levels
  assign cmp_rise = (cmp_sync_reg[1] == cmp_sync_reg[2]) &&
                    cmp_sync_reg[2] && !cmp_level_reg;
  assign rtc_rise = (rtc_sync_reg[1] == rtc_sync_reg[2]) &&
                    rtc_sync_reg[2] && !rtc_level_reg;

  // system clock by twelve and rtc edges by eight
  always @(posedge clk) begin
    if (sys_rst) begin
      div12_reg <= 4'h0;
      rtc_div_reg <= 3'h0;
    end else begin
      if (div12_tick)
        div12_reg <= 4'h0;
      else
        div12_reg <= div12_reg + 4'h1;
      if (rtc_rise)
        rtc_div_reg <= rtc_div_reg + 3'h1;
    end
  end

  assign div12_tick = (div12_reg == (`SATS_SYSTEM_CLOCK_DIV - 4'h1));
  assign rtc8_tick = rtc_rise && (rtc_div_reg == `SATS_RTC_DIV);

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  reg ext_tick;
  reg trig_tick;
  wire tick_low;
  wire tick_high;

  // external count source and capture trigger
  always @* begin
    case (external_source_select_reg)
      `SATS_SEL_COMPARATOR: ext_tick = cmp_rise;
      `SATS_SEL_RTC_DIV8: ext_tick = rtc8_tick;
      default: ext_tick = div12_tick;
    endcase
    if (external_source_select_reg[1])
      trig_tick = cmp_rise;
    else
      trig_tick = rtc8_tick;
  end

  // per byte choice of system clock or shared external source
  assign tick_low = clock_control_reg[`SATS_CKC_LOW_CHOICE] ? 1'b1 :
                    ext_tick;
  assign tick_high = clock_control_reg[`SATS_CKC_HIGH_CHOICE] ? 1'b1 :
                     ext_tick;

  ////////////////////////////////////////////////////////////////////////////
  // counter next state

  reg [7:0] count_low_next;
  reg [7:0] count_high_next;
  reg low_wrap;
  reg high_wrap;

  always @* begin
    count_low_next = count_low_byte_reg;
    count_high_next = count_high_byte_reg;
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    if (split_mode_enable_reg) begin
      // low byte always runs in split operation
      if (tick_low) begin
        if (byte_top(count_low_byte_reg)) begin
          count_low_next = reload_low_byte_reg;
          low_wrap = 1'b1;
        end else
          count_low_next = count_low_byte_reg + 8'h01;
      end
      if (run_control_reg && tick_high) begin
        if (byte_top(count_high_byte_reg)) begin
          count_high_next = reload_high_byte_reg;
          high_wrap = 1'b1;
        end else
          count_high_next = count_high_byte_reg + 8'h01;
      end
    end else if (run_control_reg && tick_low) begin
      if (byte_top(count_low_byte_reg)) begin
        low_wrap = 1'b1;
        if (byte_top(count_high_byte_reg)) begin
          count_low_next = reload_low_byte_reg;
          count_high_next = reload_high_byte_reg;
          high_wrap = 1'b1;
        end else begin
          count_low_next = 8'h00;
          count_high_next = count_high_byte_reg + 8'h01;
        end
      end else
        count_low_next = count_low_byte_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, counters and flags

  wire wr_ctrl;
  wire wr_count_low;
  wire wr_count_high;

  assign wr_ctrl = sfr_wr && (sfr_addr == `SATS_ADDR_CTRL);
  assign wr_count_low = sfr_wr && (sfr_addr == `SATS_ADDR_COUNT_LOW);
  assign wr_count_high = sfr_wr && (sfr_addr == `SATS_ADDR_COUNT_HIGH);

  // software writes; a counter write overrides the count in that cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      reload_low_byte_reg <= `SATS_RESET_BYTE;
      reload_high_byte_reg <= `SATS_RESET_BYTE;
      count_low_byte_reg <= `SATS_RESET_BYTE;
      count_high_byte_reg <= `SATS_RESET_BYTE;
      clock_control_reg <= `SATS_RESET_CKC;
      high_overflow_flag_reg <= 1'b0;
      low_overflow_flag_reg <= 1'b0;
      low_overflow_irq_enable_reg <= 1'b0;
      capture_enable_reg <= 1'b0;
      split_mode_enable_reg <= 1'b0;
      run_control_reg <= 1'b0;
      external_source_select_reg <= 2'h0;
    end else begin
      if (sfr_wr && sfr_addr == `SATS_ADDR_RELOAD_LOW)
        reload_low_byte_reg <= sfr_wdata;
      if (sfr_wr && sfr_addr == `SATS_ADDR_RELOAD_HIGH)
        reload_high_byte_reg <= sfr_wdata;
      if (sfr_wr && sfr_addr == `SATS_ADDR_CLOCK_CONTROL)
        clock_control_reg <= sfr_wdata;
      count_low_byte_reg <= wr_count_low ? sfr_wdata : count_low_next;
      count_high_byte_reg <= wr_count_high ? sfr_wdata : count_high_next;
      if (wr_ctrl) begin
        low_overflow_irq_enable_reg <= sfr_wdata[`SATS_CTRL_LOW_IRQ_EN];
        capture_enable_reg <= sfr_wdata[`SATS_CTRL_CAPTURE_EN];
        split_mode_enable_reg <= sfr_wdata[`SATS_CTRL_SPLIT];
        run_control_reg <= sfr_wdata[`SATS_CTRL_RUN];
        external_source_select_reg <=
          sfr_wdata[`SATS_CTRL_SEL_HI:`SATS_CTRL_SEL_LO];
      end
      // hardware set wins over a software clear in the same cycle
      high_overflow_flag_reg <= high_wrap ||
        (wr_ctrl ? sfr_wdata[`SATS_CTRL_HIGH_OVF] :
         high_overflow_flag_reg);
      low_overflow_flag_reg <= low_wrap ||
        (wr_ctrl ? sfr_wdata[`SATS_CTRL_LOW_OVF] :
         low_overflow_flag_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, interrupt and capture trigger outputs

  reg [7:0] read_value;

  // address decode for reads, unmapped addresses read zero
  always @* begin
    if (sfr_addr == `SATS_ADDR_CTRL)
      read_value = {high_overflow_flag_reg, low_overflow_flag_reg,
                    low_overflow_irq_enable_reg, capture_enable_reg,
                    split_mode_enable_reg, run_control_reg,
                    external_source_select_reg};
    else if (sfr_addr == `SATS_ADDR_RELOAD_LOW)
      read_value = reload_low_byte_reg;
    else if (sfr_addr == `SATS_ADDR_RELOAD_HIGH)
      read_value = reload_high_byte_reg;
    else if (sfr_addr == `SATS_ADDR_COUNT_LOW)
      read_value = count_low_byte_reg;
    else if (sfr_addr == `SATS_ADDR_COUNT_HIGH)
      read_value = count_high_byte_reg;
    else if (sfr_addr == `SATS_ADDR_CLOCK_CONTROL)
      read_value = clock_control_reg;
    else
      read_value = 8'h00;
  end

  // registered outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      timer_irq <= 1'b0;
      capture_trigger <= 1'b0;
    end else begin
      sfr_rdata <= read_value;
      timer_irq <= timer_irq_enable && (high_overflow_flag_reg ||
        (low_overflow_irq_enable_reg && low_overflow_flag_reg));
      capture_trigger <= trig_tick;
    end
  end

endmodule

`default_nettype wire

// file: verification/sats_timer_chk.sv
`default_nettype none
module sats_timer_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // sources and events
  input wire logic comparator_out,
  input wire logic rtc_osc,
  input wire logic timer_irq_enable,
  input wire logic timer_irq,
  input wire logic capture_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_reg, hi_reg, ck_reg;
  logic [5:0] ct_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // shadow copies of the software-owned fields
  always @(posedge clk) begin
    if (sys_rst) begin
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      ck_reg <= 8'h00;
      ct_reg <= 6'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'hCA) lo_reg <= sfr_wdata;
      if (sfr_addr == 8'hCB) hi_reg <= sfr_wdata;
      if (sfr_addr == 8'h8E) ck_reg <= sfr_wdata;
      if (sfr_addr == 8'hC8) ct_reg <= sfr_wdata[5:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register readback one cycle after the address
  a_reload_low_rd: assert property (
    sfr_addr == 8'hCA && !sfr_wr |=> sfr_rdata == $past(lo_reg))
    else $error("reload low readback wrong");
  a_reload_high_rd: assert property (
    sfr_addr == 8'hCB && !sfr_wr |=> sfr_rdata == $past(hi_reg))
    else $error("reload high readback wrong");
  a_clock_ctl_rd: assert property (
    sfr_addr == 8'h8E && !sfr_wr |=> sfr_rdata == $past(ck_reg))
    else $error("clock control readback wrong");
  a_mode_bits_rd: assert property (
    sfr_addr == 8'hC8 && !sfr_wr |=> sfr_rdata[5:0] == $past(ct_reg))
    else $error("control mode bits readback wrong");
  a_unmapped_zero: assert property (
    !(sfr_addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E})
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  // interrupt and capture outputs
  a_irq_gated_off: assert property (
    !timer_irq_enable |=> !timer_irq)
    else $error("interrupt while timer interrupts disabled");
  a_irq_flag_held: assert property (
    timer_irq && timer_irq_enable && !sfr_wr && !$past(sfr_wr)
    |=> timer_irq)
    else $error("interrupt dropped without software clear");
  a_capture_pulse: assert property (
    capture_trigger |=> !capture_trigger)
    else $error("capture trigger longer than one cycle");
  a_capture_quiet: assert property (
    ($stable(comparator_out) && $stable(rtc_osc))[*8] |-> !capture_trigger)
    else $error("capture trigger without a source edge");
endmodule

bind sats_timer sats_timer_chk u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .comparator_out(comparator_out),
  .rtc_osc(rtc_osc),
  .timer_irq_enable(timer_irq_enable),
  .timer_irq(timer_irq),
  .capture_trigger(capture_trigger)
);
`default_nettype wire

// file: verification/sats_timer_tb_top.sv
`default_nettype none
module sats_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic comparator_out = 1'b0;
  logic rtc_osc = 1'b0;
  logic timer_irq_enable = 1'b0;
  wire logic [7:0] sfr_rdata;
  wire logic timer_irq;
  wire logic capture_trigger;
  int error_cnt = 0;
  int checked = 0;
  int cap_cnt = 0;
  int cap_base = 0;
  int cyc = 0;
  // address, write data, expected readback
  logic [23:0] rows [5] = '{24'hCAA5A5, 24'hCB5A5A, 24'h8ECFCF,
                            24'hC9FF00, 24'h007700};
  sats_timer dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .comparator_out(comparator_out),
    .rtc_osc(rtc_osc),
    .timer_irq_enable(timer_irq_enable),
    .timer_irq(timer_irq),
    .capture_trigger(capture_trigger)
  );
  ////////////////////////////////////////////////////////////////////////
  // clock, cycle count and capture pulse count
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (capture_trigger === 1'b1) cap_cnt <= cap_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  // bus and check tasks, inputs move on the falling edge
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wr = 1'b1;
    sfr_wdata = d;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_addr = a;
    @(negedge clk);
    chk(sfr_rdata & m, e);
  endtask
  task idle(input int n);
    @(negedge clk);
    sfr_wr = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task final_report;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    wait (cyc == 5000);
    error_cnt++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'hCA, 8'hFF, 8'h00);
    rd(8'hCB, 8'hFF, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 8'hFF, rows[i][7:0]);
    end
    $display("test registers done");
    // full wrap reloads, flag set beats the clearing write
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'h8E, 8'h10);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'hFF, 8'h34);
    rd(8'hCD, 8'hFF, 8'h12);
    rd(8'hC8, 8'hC0, 8'hC0);
    timer_irq_enable = 1'b1;
    idle(2);
    chk({7'h00, timer_irq}, 8'h01);
    wr(8'hC8, 8'h00);
    idle(2);
    chk({7'h00, timer_irq}, 8'h00);
    $display("test wrap done");
    // split: low byte free running, high byte held by run control
    wr(8'hCA, 8'h80);
    wr(8'h8E, 8'h30);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFE);
    wr(8'hC8, 8'h08);
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'hFF, 8'h80);
    rd(8'hCD, 8'hFF, 8'hFE);
    rd(8'hC8, 8'hC0, 8'h40);
    idle(2);
    chk({7'h00, timer_irq}, 8'h00);
    wr(8'hC8, 8'h60);
    idle(4);
    chk({7'h00, timer_irq}, 8'h01);
    wr(8'hC8, 8'h00);
    timer_irq_enable = 1'b0;
    $display("test split done");
    // every select code: count source and capture trigger
    wr(8'h8E, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h00);
      wr(8'hC8, 8'h14 | s[7:0]);
      idle(1);
      cap_base = cap_cnt;
      for (int i = 0; i < 16; i++) begin
        rtc_osc = 1'b1;
        comparator_out = (i % 4 == 0);
        repeat (6) @(negedge clk);
        rtc_osc = 1'b0;
        comparator_out = 1'b0;
        repeat (6) @(negedge clk);
      end
      wr(8'hC8, 8'h10);
      chk(8'(cap_cnt - cap_base), s[1] ? 8'h04 : 8'h02);
      if (s[0]) rd(8'hCC, 8'hFF, s[1] ? 8'h02 : 8'h04);
      else rd(8'hCC, 8'hF0, 8'h10);
    end
    // split with the shared comparator source on both bytes
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h0D);
    idle(1);
    for (int i = 0; i < 2; i++) begin
      comparator_out = 1'b1;
      repeat (6) @(negedge clk);
      comparator_out = 1'b0;
      repeat (6) @(negedge clk);
    end
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'hFF, 8'h02);
    rd(8'hCD, 8'hFF, 8'h02);
    $display("test sources done");
    // mid-run reset clears written registers
    wr(8'hCA, 8'h5A);
    wr(8'hC8, 8'h2C);
    idle(1);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'hCA, 8'hFF, 8'h00);
    rd(8'hCB, 8'hFF, 8'h00);
    rd(8'hC8, 8'hFF, 8'h00);
    $display("test reset done");
    idle(2);
    final_report;
  end
endmodule
`default_nettype wire
